// ==== shared/lfs_pkg.sv ====
// Shared constants and types for the LED driver fault supervisor
package lfs_pkg;

  // Channel and detector counts
  localparam int NUM_CH  = 3;
  localparam int NUM_DET = 3;

  // Detector indices within a channel
  localparam int DET_OPEN   = 0;
  localparam int DET_SHORT  = 1;
  localparam int DET_SINGLE = 2;

  // Core clock rate
  localparam int CLK_HZ = 25_000_000;

  // Deglitch time in microseconds (2 ms typical, 1 to 3 ms window)
  localparam int DEGLITCH_US  = 2000;
  localparam int DEGLITCH_CYC = DEGLITCH_US * (CLK_HZ / 1_000_000);

  // Consecutive PWM cycles needed to qualify (7 to 8 window)
  localparam int PWM_QUAL_CYC = 7;
  localparam int PWM_CNT_W    = 3;

  // Cycles a driven error line is given to reach the sense path
  localparam logic [2:0] LINE_SETTLE = 3'h4;

  // Current level codes, percent of normal setting
  localparam int            LEVEL_W     = 8;
  localparam logic [7:0]    LEVEL_FULL  = 8'h64;
  localparam logic [7:0]    LEVEL_FLOOR = 8'h32;

  // Asynchronous pin and comparator inputs, synchronised together
  typedef struct packed {
    logic                enable;        // Enable pin
    logic [NUM_CH-1:0]   dim;           // Per-channel dimming input
    logic [NUM_CH-1:0]   det_open;      // Open-load comparators
    logic [NUM_CH-1:0]   det_short;     // Output-short comparators
    logic [NUM_CH-1:0]   det_single;    // Single-LED short comparators
    logic                supply_ok;     // Supply above single-short threshold
    logic                thermal;       // Thermal shutdown comparator
    logic                ref_bad;       // Reference resistor open or short
    logic                fold_hot;      // Foldback temperature reached
    logic                fold_off;      // Foldback threshold pin grounded
    logic                gen_sense;     // Sensed general error line
    logic                ss_sense;      // Sensed single-short error line
  } lfs_pins_t;

  // Per-line drive state
  typedef struct packed {
    logic       ext_high;               // Line found held high outside
    logic [2:0] age;                    // Cycles since drive began
  } lfs_line_t;

endpackage : lfs_pkg

// ==== core/lfs_fault_supervisor.sv ====
// Fault supervisor for a three-channel linear LED driver
//
// Behaviour
// - Detector faults qualify after 2 ms or 7 cycles
// - Single-short on own line, rest on general
// - Listed fault types pull the error line low
// - Thermal and open faults release line themselves
// - Other faults stay latched until reset event
// - Release on external high, enable toggle, reset
// - Without controller only power cycle clears
// - Open-drain error outputs, weak pull-up outside
// - Low general line shuts all but open channels down
// - Dim input low disables and gates channel
// - Grounded threshold pin disables thermal foldback
// - Open load: open channel on, others off
// - Line held high: only shorted channel off
// - Single-short checked only with supply above 9V
// - Single-short channel keeps sourcing current
`timescale 1ns/1ps

module lfs_fault_supervisor
  import lfs_pkg::*;
#(
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire lfs_pins_t            pins_in,
  input  wire logic [LEVEL_W-1:0]   fold_request,
  output logic [NUM_CH-1:0]         channel_on,
  output logic [LEVEL_W-1:0]        channel_level,
  output logic                      gen_err_out,
  output logic                      gen_err_oe,
  output logic                      ss_err_out,
  output logic                      ss_err_oe
);

  localparam int TW = $clog2(DEGLITCH_CYCLES + 1);
  localparam logic [TW-1:0] T_MAX = TW'(DEGLITCH_CYCLES);
  localparam logic [PWM_CNT_W-1:0] P_MAX = PWM_CNT_W'(PWM_QUAL_CYC);

  lfs_pins_t              sync1;          // First stage, read by pin_s only
  lfs_pins_t              pin_s;          // Second stage, safe to use
  logic [NUM_CH-1:0]      dim_prev;       // Dim input one cycle back
  logic [NUM_DET-1:0][NUM_CH-1:0] cond;   // Live detector conditions
  logic [NUM_DET-1:0][NUM_CH-1:0] qual;   // Deglitched detector results
  logic [NUM_CH-1:0]      open_flag;      // Self-clearing open-load fault
  logic [NUM_CH-1:0]      short_lat;      // Latched output short
  logic [NUM_CH-1:0]      ss_lat;         // Latched single-LED short
  logic                   ref_lat;        // Latched reference fault
  logic [NUM_CH-1:0]      next_open_flag;
  logic [NUM_CH-1:0]      next_short_lat;
  logic [NUM_CH-1:0]      next_ss_lat;
  logic                   next_ref_lat;
  lfs_line_t              gen_line;       // General line drive state
  lfs_line_t              ss_line;        // Single-short line drive state
  lfs_line_t              next_gen_line;
  lfs_line_t              next_ss_line;
  logic                   gen_want;       // Some general fault present
  logic                   ss_want;        // Some single-short present
  logic [NUM_CH-1:0]      next_channel_on;
  logic [LEVEL_W-1:0]     next_channel_level;
  logic                   next_gen_err_oe;
  logic                   next_ss_err_oe;

  // two-stage synchroniser for every pins_in input; fold_request is used directly
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1    <= '0;
      pin_s    <= '0;
      dim_prev <= '0;
    end else begin
      sync1    <= pins_in;
      pin_s    <= sync1;
      dim_prev <= pin_s.dim;
    end
  end

  // Detector conditions; single-short masked by low supply
  always_comb begin
    cond[DET_OPEN]   = pin_s.det_open;
    cond[DET_SHORT]  = pin_s.det_short;
    cond[DET_SINGLE] = pin_s.det_single & {NUM_CH{pin_s.supply_ok}};
  end

  // One deglitch filter per detector per channel
  for (genvar d = 0; d < NUM_DET; d++) begin : g_det
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [TW-1:0]        tcnt;        // Time run, in clock cycles
      logic [TW-1:0]        next_tcnt;
      logic [PWM_CNT_W-1:0] pcnt;        // Run of faulty PWM cycles
      logic [PWM_CNT_W-1:0] next_pcnt;
      logic                 run_ok;      // Condition held all on-time
      logic                 next_run_ok;

      // Counts only while the channel is on; off-time says nothing
      always_comb begin
        next_tcnt   = tcnt;
        next_pcnt   = pcnt;
        next_run_ok = run_ok;
        if (!pin_s.enable) begin
          // enable low clears; a saturated count must not relatch
          next_tcnt   = '0;
          next_pcnt   = '0;
          next_run_ok = 1'b0;
        end else if (pin_s.dim[c]) begin
          // New on-time starts a fresh run check
          if (!dim_prev[c]) begin
            next_run_ok = 1'b1;
          end
          // any clean sample restarts both counts
          if (!cond[d][c]) begin
            next_tcnt   = '0;
            next_pcnt   = '0;
            next_run_ok = 1'b0;
          end else if (tcnt != T_MAX) begin
            next_tcnt = tcnt + TW'(1);
          end
        end else if (dim_prev[c]) begin
          // End of on-time: score the PWM cycle
          next_tcnt   = '0;
          next_run_ok = 1'b0;
          if (!run_ok) begin
            next_pcnt = '0;
          end else if (pcnt != P_MAX) begin
            next_pcnt = pcnt + PWM_CNT_W'(1);
          end
        end
      end

      // Filter registers
      always_ff @(posedge core_clk) begin
        if (srst) begin
          tcnt   <= '0;
          pcnt   <= '0;
          run_ok <= 1'b0;
        end else begin
          tcnt   <= next_tcnt;
          pcnt   <= next_pcnt;
          run_ok <= next_run_ok;
        end
      end

      assign qual[d][c] = (tcnt == T_MAX) || (pcnt == P_MAX);
    end
  end

  // Fault flags; an arriving fault beats a clear in the same cycle
  always_comb begin
    // open flag drops when condition goes away
    next_open_flag = qual[DET_OPEN] | (open_flag & cond[DET_OPEN]);
    // sticky until enable low or reset
    next_short_lat = qual[DET_SHORT]
                   | (short_lat & {NUM_CH{pin_s.enable}});
    next_ss_lat    = qual[DET_SINGLE]
                   | (ss_lat & {NUM_CH{pin_s.enable}});
    next_ref_lat   = pin_s.ref_bad | (ref_lat & pin_s.enable);
    // every listed fault requests a pull-down
    gen_want = pin_s.thermal | ref_lat | (|open_flag) | (|short_lat);
    ss_want  = |ss_lat;
  end

  // Fault flag registers; srst is the power cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      open_flag <= '0;
      short_lat <= '0;
      ss_lat    <= '0;
      ref_lat   <= 1'b0;
    end else begin
      open_flag <= next_open_flag;
      short_lat <= next_short_lat;
      ss_lat    <= next_ss_lat;
      ref_lat   <= next_ref_lat;
    end
  end

  // Line drive state; sense is trusted only after the settle delay,
  // otherwise the synchroniser lag would look like an outside pull-up
  always_comb begin
    next_gen_line = gen_line;
    next_ss_line  = ss_line;
    if (gen_err_oe) begin
      if (gen_line.age != LINE_SETTLE) begin
        next_gen_line.age = gen_line.age + 3'h1;
      end
    end else begin
      next_gen_line.age = '0;
    end
    if (ss_err_oe) begin
      if (ss_line.age != LINE_SETTLE) begin
        next_ss_line.age = ss_line.age + 3'h1;
      end
    end else begin
      next_ss_line.age = '0;
    end
    // outside high seen while driving: let go
    if (gen_line.age == LINE_SETTLE && pin_s.gen_sense) begin
      next_gen_line.ext_high = 1'b1;
    end else if (!pin_s.enable) begin
      next_gen_line.ext_high = 1'b0;
    end
    if (ss_line.age == LINE_SETTLE && pin_s.ss_sense) begin
      next_ss_line.ext_high = 1'b1;
    end else if (!pin_s.enable) begin
      next_ss_line.ext_high = 1'b0;
    end
    next_gen_err_oe = gen_want & ~next_gen_line.ext_high;
    next_ss_err_oe  = ss_want & ~next_ss_line.ext_high;
  end

  // Line drive registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gen_line   <= '0;
      ss_line    <= '0;
      gen_err_oe <= 1'b0;
      ss_err_oe  <= 1'b0;
    end else begin
      gen_line   <= next_gen_line;
      ss_line    <= next_ss_line;
      gen_err_oe <= next_gen_err_oe;
      ss_err_oe  <= next_ss_err_oe;
    end
  end

  // Open-drain data is always low; the enable does the work
  assign gen_err_out = 1'b0;
  assign ss_err_out  = 1'b0;

  // Channel gating and current level
  always_comb begin
    next_channel_on = pin_s.dim & {NUM_CH{pin_s.enable}};
    if (pin_s.thermal) begin
      next_channel_on = '0;
    end else if (gen_line.ext_high) begin
      // only the shorted string goes off
      next_channel_on = next_channel_on & ~short_lat;
    end else if (!pin_s.gen_sense) begin
      // except a channel with its own open load
      next_channel_on = next_channel_on & open_flag;
    end
    next_channel_level = LEVEL_FULL;
    if (pin_s.fold_hot && !pin_s.fold_off) begin
      // reduced level never under the floor
      if (fold_request < LEVEL_FLOOR) begin
        next_channel_level = LEVEL_FLOOR;
      end else if (fold_request > LEVEL_FULL) begin
        next_channel_level = LEVEL_FULL;
      end else begin
        next_channel_level = fold_request;
      end
    end
  end

  // Output registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      channel_on    <= '0;
      channel_level <= LEVEL_FULL;
    end else begin
      channel_on    <= next_channel_on;
      channel_level <= next_channel_level;
    end
  end

endmodule : lfs_fault_supervisor

// ==== dv/lfs_fault_bus.sv ====
// Far-side model of the shared open-drain fault lines
`timescale 1ns/1ps

module lfs_fault_bus (
  input  wire logic gen_oe,
  input  wire logic ss_oe,
  input  wire logic hold_high,
  input  wire logic peer_low,
  output logic      gen_line,
  output logic      ss_line
);
  // peers pull the general line low; the single-short line has no peer
  // A strong outside driver beats the weak on-chip pulldown
  assign gen_line = hold_high | !(gen_oe | peer_low);
  assign ss_line  = hold_high | !ss_oe;
endmodule : lfs_fault_bus

// ==== dv/lfs_fault_supervisor_properties.sv ====
// Port checker for the LED driver fault supervisor
`timescale 1ns/1ps

module lfs_checker
  import lfs_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               srst,
  input wire lfs_pins_t          pins_in,
  input wire logic [LEVEL_W-1:0] fold_request,
  input wire logic [NUM_CH-1:0]  channel_on,
  input wire logic [LEVEL_W-1:0] channel_level,
  input wire logic               gen_err_out,
  input wire logic               gen_err_oe,
  input wire logic               ss_err_out,
  input wire logic               ss_err_oe
);
  default clocking cb @(posedge core_clk); endclocking
  // Pins need two sync stages plus a register, hence the repeats
  chk_reset_state: assert property (
    srst |=> channel_on == 0 && !gen_err_oe && !ss_err_oe)
    else $error("outputs not cleared by reset");
  chk_drain_only: assert property (
    disable iff (srst) !gen_err_out && !ss_err_out)
    else $error("error data not low");
  chk_dim_gate: assert property (
    disable iff (srst) !pins_in.dim[0] [*4] |-> !channel_on[0])
    else $error("channel on with dim low");
  chk_thermal_off: assert property (
    disable iff (srst) pins_in.thermal [*4] |-> channel_on == 0)
    else $error("channel on in thermal fault");
  chk_gen_release: assert property (
    disable iff (srst)
    gen_err_oe && pins_in.gen_sense |-> ##[1:10] !gen_err_oe)
    else $error("general line not released");
  chk_ss_release: assert property (
    disable iff (srst)
    ss_err_oe && pins_in.ss_sense |-> ##[1:10] !ss_err_oe)
    else $error("single line not released");
  chk_ss_supply: assert property (
    disable iff (srst) $rose(ss_err_oe) |-> $past(pins_in.supply_ok))
    else $error("single short with low supply");
  chk_ss_clear: assert property (
    disable iff (srst)
    (!pins_in.enable && pins_in.det_single == 0) [*6] |-> !ss_err_oe)
    else $error("single line kept with enable low");
  chk_ss_latched: assert property (
    disable iff (srst)
    (pins_in.enable && !pins_in.ss_sense) [*5] ##0 ss_err_oe
    |=> ss_err_oe)
    else $error("single line dropped by itself");
  chk_fold_off: assert property (
    disable iff (srst) pins_in.fold_off [*4] |-> channel_level == LEVEL_FULL)
    else $error("foldback while pin grounded");
  chk_level_floor: assert property (
    disable iff (srst)
    channel_level >= LEVEL_FLOOR && channel_level <= LEVEL_FULL)
    else $error("level outside floor and full");
  cov_gen: cover property (disable iff (srst) $rose(gen_err_oe));
  cov_ss: cover property (disable iff (srst) $rose(ss_err_oe));
  cov_fold: cover property (disable iff (srst) channel_level == LEVEL_FLOOR);
endmodule : lfs_checker

bind lfs_fault_supervisor lfs_checker chk_u (.core_clk, .srst, .pins_in,
  .fold_request, .channel_on, .channel_level, .gen_err_out, .gen_err_oe,
  .ss_err_out, .ss_err_oe);

// ==== dv/led_driver_fault_supervisor_bench.sv ====
// Self-checking bench for the LED driver fault supervisor
`timescale 1ns/1ps

module led_driver_fault_supervisor_bench
  import lfs_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic       hold_high = 1'b0;
  logic       peer_low = 1'b0;
  logic [7:0] fold_request = 8'h64;
  lfs_pins_t  p;
  lfs_pins_t  pins;
  logic [2:0] channel_on;
  logic [7:0] channel_level;
  logic       gen_err_oe, ss_err_oe, gen_line, ss_line;
  logic       gen_err_out, ss_err_out;
  int         n_mismatch = 0;
  int         checks_done = 0;

  always #20 core_clk = ~core_clk;
  // Sensed lines come back from the bus model
  always_comb begin
    pins = p;
    pins.gen_sense = gen_line;
    pins.ss_sense = ss_line;
  end

  // Short deglitch keeps the run brief
  lfs_fault_supervisor #(.DEGLITCH_CYCLES(20)) dut_u (.core_clk, .srst,
    .pins_in(pins), .fold_request, .channel_on, .channel_level,
    .gen_err_out, .gen_err_oe, .ss_err_out, .ss_err_oe);
  lfs_fault_bus bus_u (.gen_oe(gen_err_oe), .ss_oe(ss_err_oe), .hold_high,
    .peer_low, .gen_line, .ss_line);

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Bounded wait for a line drive to reach a level
  task automatic wait_oe(input bit ss, input logic want);
    int k;
    for (k = 0; k < 80 && (ss ? ss_err_oe : gen_err_oe) !== want; k++)
      cyc(1);
    if (k == 80) begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      results();
    end
  endtask : wait_oe

  task automatic power_cycle();
    srst = 1'b1;
    cyc(3);
    srst = 1'b0;
    cyc(4);
  endtask : power_cycle

  task automatic pwm(input int n);
    repeat (n) begin
      p.dim[0] = 1'b1;
      cyc(5);
      p.dim[0] = 1'b0;
      cyc(5);
    end
  endtask : pwm

  task automatic t_short();
    p.det_short[1] = 1'b1;
    cyc(12);
    p.det_short[1] = 1'b0;
    cyc(1);
    p.det_short[1] = 1'b1;
    cyc(16);
    check(gen_err_oe, 1'b0);
    wait_oe(0, 1'b1);
    // Sensed line needs two sync stages plus the output register
    cyc(4);
    check(channel_on, 3'h0);
    p.det_short[1] = 1'b0;
    cyc(30);
    check(gen_err_oe, 1'b1);
    p.enable = 1'b0;
    wait_oe(0, 1'b0);
    p.enable = 1'b1;
    cyc(4);
    check(channel_on, 3'h7);
    $display("short done");
  endtask : t_short

  task automatic t_pwm();
    // Channel 0 is left to the pwm task alone
    p.dim[2:1] = 2'h0;
    p.det_short[0] = 1'b1;
    pwm(6);
    check(gen_err_oe, 1'b0);
    pwm(2);
    wait_oe(0, 1'b1);
    p.det_short[0] = 1'b0;
    power_cycle();
    p.dim = 3'h7;
    $display("pwm done");
  endtask : t_pwm

  task automatic t_open();
    p.det_open[0] = 1'b1;
    wait_oe(0, 1'b1);
    cyc(4);
    check(channel_on, 3'h1);
    p.det_open[0] = 1'b0;
    wait_oe(0, 1'b0);
    p.thermal = 1'b1;
    wait_oe(0, 1'b1);
    cyc(4);
    check(channel_on, 3'h0);
    p.thermal = 1'b0;
    wait_oe(0, 1'b0);
    peer_low = 1'b1;
    cyc(4);
    check(channel_on, 3'h0);
    peer_low = 1'b0;
    $display("open done");
  endtask : t_open

  task automatic t_single();
    p.supply_ok = 1'b0;
    p.det_single[2] = 1'b1;
    cyc(40);
    check(ss_err_oe, 1'b0);
    p.supply_ok = 1'b1;
    wait_oe(1, 1'b1);
    check(gen_err_oe, 1'b0);
    check(channel_on, 3'h7);
    p.det_single[2] = 1'b0;
    p.enable = 1'b0;
    cyc(8);
    check(ss_err_oe, 1'b0);
    p.enable = 1'b1;
    p.det_single[2] = 1'b1;
    wait_oe(1, 1'b1);
    p.det_single[2] = 1'b0;
    p.ref_bad = 1'b1;
    wait_oe(0, 1'b1);
    p.ref_bad = 1'b0;
    cyc(30);
    check({gen_err_oe, ss_err_oe}, 2'h3);
    power_cycle();
    check({gen_err_oe, ss_err_oe}, 2'h0);
    $display("single done");
  endtask : t_single

  task automatic t_hold();
    hold_high = 1'b1;
    p.det_short[2] = 1'b1;
    wait_oe(0, 1'b1);
    wait_oe(0, 1'b0);
    cyc(4);
    check(channel_on, 3'h3);
    p.det_short[2] = 1'b0;
    hold_high = 1'b0;
    power_cycle();
    $display("hold done");
  endtask : t_hold

  task automatic t_fold();
    p.fold_hot = 1'b1;
    fold_request = 8'h10;
    cyc(4);
    check(channel_level, 8'h32);
    fold_request = 8'h50;
    cyc(2);
    check(channel_level, 8'h50);
    p.fold_off = 1'b1;
    cyc(4);
    check(channel_level, 8'h64);
    $display("fold done");
  endtask : t_fold

  initial begin
    p = '0;
    p.enable = 1'b1;
    p.dim = 3'h7;
    p.supply_ok = 1'b1;
    cyc(3);
    check({channel_on, gen_err_oe, ss_err_oe}, 8'h00);
    srst = 1'b0;
    cyc(4);
    check(channel_on, 3'h7);
    check({gen_err_out, ss_err_out}, 8'h00);
    t_short();
    t_pwm();
    t_open();
    t_single();
    t_hold();
    t_fold();
    results();
  end
endmodule : led_driver_fault_supervisor_bench
